// *** src/em_irq_status.sv ***
// Purpose: status flags, enables, summary interrupt and calibration mode
// Assumes: all inputs synchronous to clk_sys; events are one-cycle pulses
// Notes: status flags clear by writing zero to the bit; set wins
`timescale 1ns/1ns
`default_nettype none
module em_irq_status (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire em_pkg::em_sfr_req_s sfr_req,
  output var logic [7:0] sfr_rdata,
  // measurement events
  input wire em_pkg::em_evt_s evt,
  input wire logic fault_dir_sel,
  input wire logic reactive_dir_sel,
  input wire logic active_dir_sel,
  input wire logic tamper_pick_b,
  input wire logic [em_pkg::MAG_W-1:0] current_magnitude,
  input wire logic [em_pkg::MAG_W-1:0] current_peak_threshold,
  input wire logic [em_pkg::MAG_W-1:0] voltage_magnitude,
  input wire logic [em_pkg::MAG_W-1:0] voltage_peak_threshold,
  input wire logic [em_pkg::ZERO_CROSS_TIMEOUT_FLAG_W-1:0] zero_cross_timeout_count,
  input wire logic [em_pkg::CYC_W-1:0] line_cycle_count,
  // interrupt and input routing
  output var logic irq_pending,
  output var logic current_use_a,
  output var logic current_use_b,
  output var logic voltage_input_ground,
  output var logic current_input_ground
);
  import em_pkg::*;

  em_state_s q_reg;
  em_state_s q_next;
  logic [7:0] set_l;
  logic [7:0] set_m;
  logic [7:0] set_h;
  logic zx_ev;
  logic wr_l;
  logic wr_m;
  logic wr_h;
  logic [1:0] sel;
  logic [ZERO_CROSS_TIMEOUT_FLAG_W-1:0] zx_inc;
  logic [CYC_W-1:0] cyc_inc;

  // ****************************************************************
  // event detection
  // ****************************************************************
  always_comb begin
    zx_ev = evt.voltage_sign != q_reg.vsgn_prev;
    zx_inc = q_reg.zx_cnt + ZERO_CROSS_TIMEOUT_FLAG_W'(1);
    cyc_inc = q_reg.cyc_cnt + CYC_W'(1);
    set_l = 8'h00;
    set_m = 8'h00;
    set_h = 8'h00;
    set_l[FAULT_BIT] = fault_dir_sel ? (q_reg.flt_prev & ~evt.fault_mode)
                                     : (~q_reg.flt_prev & evt.fault_mode);
    set_l[REACT_SIGN_BIT] = reactive_dir_sel ? (q_reg.rea_prev & ~evt.reactive_neg)
                                             : (~q_reg.rea_prev & evt.reactive_neg);
    set_l[ACT_SIGN_BIT] = active_dir_sel ? (q_reg.act_prev & ~evt.active_neg)
                                         : (~q_reg.act_prev & evt.active_neg);
    set_l[APP_NOLOAD_BIT] = evt.apparent_noload | evt.irms_noload;
    set_l[REACT_NOLOAD_BIT] = evt.reactive_noload;
    set_l[ACT_NOLOAD_BIT] = evt.active_noload;
    set_m[PULSE_B_BIT] = evt.pulse_out_b;
    set_m[PULSE_A_BIT] = evt.pulse_out_a;
    set_m[APP_OVF_BIT] = evt.apparent_ovf;
    set_m[REACT_OVF_BIT] = evt.reactive_ovf;
    set_m[ACT_OVF_BIT] = evt.active_ovf;
    set_m[APP_HALF_BIT] = evt.apparent_half;
    set_m[REACT_HALF_BIT] = evt.reactive_half;
    set_m[ACT_HALF_BIT] = evt.active_half;
    set_h[RESET_END_BIT] = ~q_reg.reset_seen | evt.soft_reset_done;
    set_h[WAVE_BIT] = evt.waveform_write;
    set_h[IPEAK_BIT] = current_magnitude > current_peak_threshold;
    set_h[VPEAK_BIT] = voltage_magnitude > voltage_peak_threshold;
    set_h[CYCLE_END_FLAG_BIT] = zx_ev && (cyc_inc >= line_cycle_count);
    set_h[ZERO_CROSS_TIMEOUT_FLAG_BIT] = !zx_ev && evt.half_cycle_tick && (zero_cross_timeout_count != '0)
                      && (zx_inc >= zero_cross_timeout_count);
    set_h[ZX_BIT] = zx_ev;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    q_next = q_reg;
    wr_l = sfr_req.wr && (sfr_req.addr == ST_L_ADDR);
    wr_m = sfr_req.wr && (sfr_req.addr == ST_M_ADDR);
    wr_h = sfr_req.wr && (sfr_req.addr == ST_H_ADDR);
    q_next.flt_prev = evt.fault_mode;
    q_next.rea_prev = evt.reactive_neg;
    q_next.act_prev = evt.active_neg;
    q_next.vsgn_prev = evt.voltage_sign;
    q_next.reset_seen = 1'b1;
    if (zx_ev) begin
      q_next.zx_cnt = '0;
    end else if (set_h[ZERO_CROSS_TIMEOUT_FLAG_BIT]) begin
      q_next.zx_cnt = '0;
    end else if (evt.half_cycle_tick) begin
      q_next.zx_cnt = zx_inc;
    end
    if (set_h[CYCLE_END_FLAG_BIT]) begin
      q_next.cyc_cnt = '0;
    end else if (zx_ev) begin
      q_next.cyc_cnt = cyc_inc;
    end
    if (sfr_req.wr) begin
      if (sfr_req.addr == CAL_ADDR) begin
        q_next.cal = sfr_req.wdata & CAL_WMASK;
      end else if (sfr_req.addr == EN_L_ADDR) begin
        q_next.en_l = sfr_req.wdata & EN_L_MASK;
      end else if (sfr_req.addr == EN_M_ADDR) begin
        q_next.en_m = sfr_req.wdata & EN_M_MASK;
      end else if (sfr_req.addr == EN_H_ADDR) begin
        q_next.en_h = sfr_req.wdata & EN_H_MASK;
      end
    end
    // write zero clears, a same-cycle event still sets
    q_next.st_l = ((wr_l ? (q_reg.st_l & sfr_req.wdata) : q_reg.st_l) | set_l) & EN_L_MASK;
    q_next.st_m = (wr_m ? (q_reg.st_m & sfr_req.wdata) : q_reg.st_m) | set_m;
    q_next.st_h = ((wr_h ? (q_reg.st_h & sfr_req.wdata) : q_reg.st_h) | set_h) & ST_H_MASK;
    q_next.st_l[SUMMARY_BIT] = |(q_next.st_l & q_next.en_l) | |(q_next.st_m & q_next.en_m)
                               | |(q_next.st_h & q_next.en_h);
    q_next.irq = q_next.st_l[SUMMARY_BIT];
    sel = q_next.cal[CAL_SEL_LSB +: 2];
    if (sel == SEL_A) begin
      q_next.sel_a = 1'b1;
      q_next.sel_b = 1'b0;
    end else if (sel == SEL_B) begin
      q_next.sel_a = 1'b0;
      q_next.sel_b = 1'b1;
    end else begin
      q_next.sel_a = ~tamper_pick_b;
      q_next.sel_b = tamper_pick_b;
    end
    q_next.v_gnd = q_next.cal[CAL_VGND_BIT];
    q_next.i_gnd = q_next.cal[CAL_IGND_BIT];
    if (sfr_req.rd) begin
      if (sfr_req.addr == CAL_ADDR) begin
        q_next.rdata = q_reg.cal;
      end else if (sfr_req.addr == EN_L_ADDR) begin
        q_next.rdata = q_reg.en_l;
      end else if (sfr_req.addr == EN_M_ADDR) begin
        q_next.rdata = q_reg.en_m;
      end else if (sfr_req.addr == EN_H_ADDR) begin
        q_next.rdata = q_reg.en_h;
      end else if (sfr_req.addr == ST_L_ADDR) begin
        q_next.rdata = q_reg.st_l;
      end else if (sfr_req.addr == ST_M_ADDR) begin
        q_next.rdata = q_reg.st_m;
      end else if (sfr_req.addr == ST_H_ADDR) begin
        q_next.rdata = q_reg.st_h;
      end else begin
        q_next.rdata = REG_RESET;
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign sfr_rdata = q_reg.rdata;
  assign irq_pending = q_reg.irq;
  assign current_use_a = q_reg.sel_a;
  assign current_use_b = q_reg.sel_b;
  assign voltage_input_ground = q_reg.v_gnd;
  assign current_input_ground = q_reg.i_gnd;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence clear_active_noload;
    sfr_req.wr && (sfr_req.addr == ST_L_ADDR) && !sfr_req.wdata[ACT_NOLOAD_BIT];
  endsequence

  summary_set_a: assert property (
    (|(q_reg.st_l[5:0] & q_reg.en_l[5:0]) || |(q_reg.st_m & q_reg.en_m)
     || |(q_reg.st_h[5:0] & q_reg.en_h[5:0])) |-> (q_reg.st_l[SUMMARY_BIT] && irq_pending))
    else $error("summary bit low with enabled flag set");
  summary_clear_a: assert property (
    !(|(q_reg.st_l[5:0] & q_reg.en_l[5:0]) || |(q_reg.st_m & q_reg.en_m)
      || |(q_reg.st_h[5:0] & q_reg.en_h[5:0])) |-> !q_reg.st_l[SUMMARY_BIT] && !irq_pending)
    else $error("summary bit stuck without enabled flag");
  fault_enter_a: assert property (
    (!fault_dir_sel && evt.fault_mode && !q_reg.flt_prev) |=> q_reg.st_l[FAULT_BIT])
    else $error("fault change not flagged");
  active_sign_a: assert property (
    (active_dir_sel && !evt.active_neg && q_reg.act_prev) |=> q_reg.st_l[ACT_SIGN_BIT])
    else $error("active sign change not flagged");
  pulse_flag_a: assert property (
    evt.pulse_out_a |=> q_reg.st_m[PULSE_A_BIT])
    else $error("pulse flag a not set");
  set_wins_a: assert property (
    (clear_active_noload and evt.active_noload) |=> q_reg.st_l[ACT_NOLOAD_BIT])
    else $error("event lost during clear");
  clear_works_a: assert property (
    (clear_active_noload and !evt.active_noload) |=> !q_reg.st_l[ACT_NOLOAD_BIT])
    else $error("flag not cleared by write");
  select_fixed_a: assert property (
    (q_reg.cal[CAL_SEL_LSB +: 2] == SEL_B) |-> (!current_use_a && current_use_b))
    else $error("channel b select ignored");
  ground_follow_a: assert property (
    (sfr_req.wr && sfr_req.addr == CAL_ADDR && sfr_req.wdata[CAL_IGND_BIT])
    |=> current_input_ground && q_reg.cal[CAL_IGND_BIT])
    else $error("current ground not applied");
  reset_end_a: assert property (
    !q_reg.reset_seen |=> q_reg.st_h[RESET_END_BIT] [*1] ##0 q_reg.reset_seen)
    else $error("reset end flag missing");
  zero_cross_a: assert property (
    (evt.voltage_sign != q_reg.vsgn_prev) |=> q_reg.st_h[ZX_BIT] && (q_reg.zx_cnt == '0))
    else $error("zero crossing not flagged");

  sequence cal_write;
    sfr_req.wr && (sfr_req.addr == CAL_ADDR);
  endsequence

  fault_leave_a: assert property (
    (fault_dir_sel && !evt.fault_mode && q_reg.flt_prev) |=> q_reg.st_l[FAULT_BIT])
    else $error("fault exit not flagged");
  react_fall_a: assert property (
    (!reactive_dir_sel && evt.reactive_neg && !q_reg.rea_prev) |=> q_reg.st_l[REACT_SIGN_BIT])
    else $error("reactive sign fall not flagged");
  react_rise_a: assert property (
    (reactive_dir_sel && !evt.reactive_neg && q_reg.rea_prev) |=> q_reg.st_l[REACT_SIGN_BIT])
    else $error("reactive sign rise not flagged");
  active_fall_a: assert property (
    (!active_dir_sel && evt.active_neg && !q_reg.act_prev) |=> q_reg.st_l[ACT_SIGN_BIT])
    else $error("active sign fall not flagged");
  app_noload_a: assert property (
    (evt.apparent_noload || evt.irms_noload) |=> q_reg.st_l[APP_NOLOAD_BIT])
    else $error("apparent no-load not flagged");
  react_noload_a: assert property (
    evt.reactive_noload |=> q_reg.st_l[REACT_NOLOAD_BIT])
    else $error("reactive no-load not flagged");
  act_noload_a: assert property (
    evt.active_noload |=> q_reg.st_l[ACT_NOLOAD_BIT])
    else $error("active no-load not flagged");
  pulse_b_a: assert property (
    evt.pulse_out_b |=> q_reg.st_m[PULSE_B_BIT])
    else $error("pulse flag b not set");
  app_ovf_a: assert property (
    evt.apparent_ovf |=> q_reg.st_m[APP_OVF_BIT])
    else $error("apparent overflow not flagged");
  react_ovf_a: assert property (
    evt.reactive_ovf |=> q_reg.st_m[REACT_OVF_BIT])
    else $error("reactive overflow not flagged");
  act_ovf_a: assert property (
    evt.active_ovf |=> q_reg.st_m[ACT_OVF_BIT])
    else $error("active overflow not flagged");
  ovf_sticky_a: assert property (
    (q_reg.st_m[ACT_OVF_BIT] && !(sfr_req.wr && sfr_req.addr == ST_M_ADDR))
    |=> q_reg.st_m[ACT_OVF_BIT])
    else $error("overflow flag lost without clear");
  app_half_a: assert property (
    evt.apparent_half |=> q_reg.st_m[APP_HALF_BIT])
    else $error("apparent half-full not flagged");
  react_half_a: assert property (
    evt.reactive_half |=> q_reg.st_m[REACT_HALF_BIT])
    else $error("reactive half-full not flagged");
  act_half_a: assert property (
    evt.active_half |=> q_reg.st_m[ACT_HALF_BIT])
    else $error("active half-full not flagged");
  wave_flag_a: assert property (
    evt.waveform_write |=> q_reg.st_h[WAVE_BIT])
    else $error("waveform ready not flagged");
  ipeak_flag_a: assert property (
    (current_magnitude > current_peak_threshold) |=> q_reg.st_h[IPEAK_BIT])
    else $error("current peak not flagged");
  vpeak_flag_a: assert property (
    (voltage_magnitude > voltage_peak_threshold) |=> q_reg.st_h[VPEAK_BIT])
    else $error("voltage peak not flagged");
  cycle_end_a: assert property (
    ((evt.voltage_sign != q_reg.vsgn_prev)
     && ((q_reg.cyc_cnt + CYC_W'(1)) >= line_cycle_count))
    |=> q_reg.st_h[CYCLE_END_FLAG_BIT] && (q_reg.cyc_cnt == '0))
    else $error("cycle end not flagged");
  zx_timeout_a: assert property (
    ((evt.voltage_sign == q_reg.vsgn_prev) && evt.half_cycle_tick
     && (zero_cross_timeout_count != '0)
     && ((q_reg.zx_cnt + ZERO_CROSS_TIMEOUT_FLAG_W'(1)) >= zero_cross_timeout_count))
    |=> q_reg.st_h[ZERO_CROSS_TIMEOUT_FLAG_BIT] && (q_reg.zx_cnt == '0))
    else $error("zero cross timeout not flagged");
  pick_first_a: assert property (
    (q_reg.cal[CAL_SEL_LSB +: 2] == SEL_A) |-> (current_use_a && !current_use_b))
    else $error("channel a select ignored");
  vgnd_set_a: assert property (
    (cal_write ##0 sfr_req.wdata[CAL_VGND_BIT]) |=> voltage_input_ground)
    else $error("voltage ground not applied");
  vgnd_clear_a: assert property (
    (cal_write ##0 !sfr_req.wdata[CAL_VGND_BIT]) |=> !voltage_input_ground)
    else $error("voltage ground not released");
  ignd_clear_a: assert property (
    (cal_write ##0 !sfr_req.wdata[CAL_IGND_BIT]) |=> !current_input_ground)
    else $error("current ground not released");
  en_write_a: assert property (
    (sfr_req.wr && sfr_req.addr == EN_M_ADDR) |=> (q_reg.en_m == $past(sfr_req.wdata)))
    else $error("enable write not stored");
  status_read_a: assert property (
    (sfr_req.rd && sfr_req.addr == ST_L_ADDR) |=> (sfr_rdata == $past(q_reg.st_l)))
    else $error("status read data wrong");
endmodule
`default_nettype wire

// *** src/em_pkg.sv ***
// What this block does
// - channel select 01 picks input a, 10 input b, 00/11 tamper choice
// - voltage ground bit one ties the voltage channel input to ground
// - current ground bit one ties both current channel inputs to ground
// - summary bit set whenever any enabled status flag is set
// - summary bit clears itself once all enabled flags are cleared
// - fault change flag set on fault mode change in configured direction
// - reactive sign flag set on reactive sign change in configured direction
// - active sign flag set on active sign change in configured direction
// - apparent no-load flag set on apparent no-load or rms current no-load entry
// - reactive no-load flag set on reactive no-load detection
// - active no-load flag set on active no-load detection
// - pulse flags bits 7 and 6 set per pulse, even with pin disabled
// - overflow flags bits 5,4,3 for apparent, reactive, active accumulators
// - half-full flags bits 2,1,0 for apparent, reactive, active accumulators
// - reset-end flag set at end of software or hardware reset
// - waveform ready flag set when new sample data is written
// - current peak flag set when current magnitude exceeds its threshold
// - voltage peak flag set when voltage magnitude exceeds its threshold
// - cycle end flag set after programmed number of half line cycles
// - zero cross timeout flag set when no crossing within programmed half cycles
// - zero cross flag set on each voltage channel zero crossing
// - three enable registers mirror status bits; set enable lets flag interrupt
// - direction bit 0 fires on positive-to-negative, 1 on negative-to-positive
// Purpose: constants and carriers of the metering interrupt status block
// Assumes: single clock, special function register port of the core
// Notes: none
package em_pkg;
  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] CAL_ADDR = 8'h3D;
  localparam logic [7:0] EN_L_ADDR = 8'hD9;
  localparam logic [7:0] EN_M_ADDR = 8'hDA;
  localparam logic [7:0] EN_H_ADDR = 8'hDB;
  localparam logic [7:0] ST_L_ADDR = 8'hDC;
  localparam logic [7:0] ST_M_ADDR = 8'hDD;
  localparam logic [7:0] ST_H_ADDR = 8'hDE;
  // ****************************************************************
  // masks, fields, reset values
  // ****************************************************************
  localparam logic [7:0] CAL_WMASK = 8'h3C;
  localparam logic [7:0] EN_L_MASK = 8'h3F;
  localparam logic [7:0] EN_M_MASK = 8'hFF;
  localparam logic [7:0] EN_H_MASK = 8'h3F;
  localparam logic [7:0] ST_H_MASK = 8'hBF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CAL_SEL_LSB = 4;
  localparam int CAL_VGND_BIT = 3;
  localparam int CAL_IGND_BIT = 2;
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam int SUMMARY_BIT = 7;
  localparam int FAULT_BIT = 5;
  localparam int REACT_SIGN_BIT = 4;
  localparam int ACT_SIGN_BIT = 3;
  localparam int APP_NOLOAD_BIT = 2;
  localparam int REACT_NOLOAD_BIT = 1;
  localparam int ACT_NOLOAD_BIT = 0;
  localparam int PULSE_B_BIT = 7;
  localparam int PULSE_A_BIT = 6;
  localparam int APP_OVF_BIT = 5;
  localparam int REACT_OVF_BIT = 4;
  localparam int ACT_OVF_BIT = 3;
  localparam int APP_HALF_BIT = 2;
  localparam int REACT_HALF_BIT = 1;
  localparam int ACT_HALF_BIT = 0;
  localparam int RESET_END_BIT = 7;
  localparam int WAVE_BIT = 5;
  localparam int IPEAK_BIT = 4;
  localparam int VPEAK_BIT = 3;
  localparam int CYCLE_END_FLAG_BIT = 2;
  localparam int ZERO_CROSS_TIMEOUT_FLAG_BIT = 1;
  localparam int ZX_BIT = 0;
  localparam int MAG_W = 24;
  localparam int ZERO_CROSS_TIMEOUT_FLAG_W = 12;
  localparam int CYC_W = 16;
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } em_sfr_req_s;
  typedef struct packed {
    logic fault_mode;
    logic reactive_neg;
    logic active_neg;
    logic apparent_noload;
    logic irms_noload;
    logic reactive_noload;
    logic active_noload;
    logic pulse_out_a;
    logic pulse_out_b;
    logic apparent_ovf;
    logic reactive_ovf;
    logic active_ovf;
    logic apparent_half;
    logic reactive_half;
    logic active_half;
    logic waveform_write;
    logic voltage_sign;
    logic half_cycle_tick;
    logic soft_reset_done;
  } em_evt_s;
  typedef struct packed {
    logic [7:0] cal;
    logic [7:0] en_l;
    logic [7:0] en_m;
    logic [7:0] en_h;
    logic [7:0] st_l;
    logic [7:0] st_m;
    logic [7:0] st_h;
    logic flt_prev;
    logic rea_prev;
    logic act_prev;
    logic vsgn_prev;
    logic reset_seen;
    logic [ZERO_CROSS_TIMEOUT_FLAG_W-1:0] zx_cnt;
    logic [CYC_W-1:0] cyc_cnt;
    logic [7:0] rdata;
    logic irq;
    logic sel_a;
    logic sel_b;
    logic v_gnd;
    logic i_gnd;
  } em_state_s;
endpackage

// *** tb/em_irq_status_tb.sv ***
// Purpose: self-checking bench for the metering interrupt status block
// Assumes: read data is registered on the edge that takes the read strobe
// Notes: driver keeps a small model and queues one note per read
`timescale 1ns/1ns
`default_nettype none
module em_irq_status_tb;
  import em_pkg::*;
  // ****************************************************************
  // signals and model state
  // ****************************************************************
  logic clk_sys, reset, rd_seen, irq_pending, current_use_a, current_use_b;
  logic voltage_input_ground, current_input_ground, tamper_pick_b;
  logic fault_dir_sel, reactive_dir_sel, active_dir_sel;
  em_sfr_req_s sfr_req;
  em_evt_s evt;
  logic [7:0] sfr_rdata, cal_m, d_w;
  logic [MAG_W-1:0] cur_mag, cur_thr, volt_mag, volt_thr;
  logic [ZERO_CROSS_TIMEOUT_FLAG_W-1:0] zx_lim;
  logic [CYC_W-1:0] cyc_lim;
  logic [7:0] st[3];
  logic [7:0] en[3];
  logic [7:0] en_mask[3] = '{EN_L_MASK, EN_M_MASK, EN_H_MASK};
  int tab_e[14] = '{12, 13, 15, 14, 4, 5, 6, 7, 8, 9, 11, 10, 3, 0};
  int tab_r[14] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2};
  int tab_b[14] = '{0, 1, 2, 2, 0, 1, 2, 3, 4, 5, 6, 7, 5, 7};
  logic [12:0] notes[$];
  int err_count, checks_done, cycles, r, b;
  em_irq_status u_dut (
    .clk_sys(clk_sys), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .evt(evt),
    .fault_dir_sel(fault_dir_sel), .reactive_dir_sel(reactive_dir_sel),
    .active_dir_sel(active_dir_sel), .tamper_pick_b(tamper_pick_b),
    .current_magnitude(cur_mag), .current_peak_threshold(cur_thr),
    .voltage_magnitude(volt_mag), .voltage_peak_threshold(volt_thr),
    .zero_cross_timeout_count(zx_lim), .line_cycle_count(cyc_lim),
    .irq_pending(irq_pending), .current_use_a(current_use_a), .current_use_b(current_use_b),
    .voltage_input_ground(voltage_input_ground), .current_input_ground(current_input_ground)
  );
  // ****************************************************************
  // model and tasks
  // ****************************************************************
  function automatic logic irq_exp();
    return |(st[0][5:0] & en[0][5:0]) | |(st[1] & en[1]) | |(st[2][5:0] & en[2][5:0]);
  endfunction
  function automatic logic [12:0] note(input logic [7:0] d);
    logic [1:0] sel;
    sel = cal_m[5:4];
    return {d, irq_exp(), sel == SEL_A || (sel != SEL_B && !tamper_pick_b),
      sel == SEL_B || (sel != SEL_A && tamper_pick_b), cal_m[3], cal_m[2]};
  endfunction
  task automatic check(input string n, input logic [12:0] seen, input logic [12:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req.addr = a;
    sfr_req.wdata = d;
    sfr_req.wr = 1'b1;
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] d);
    notes.push_back(note(d));
    sfr_req.addr = a;
    sfr_req.rd = 1'b1;
    @(negedge clk_sys);
    sfr_req.rd = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic st_chk(input int k);
    logic [7:0] d;
    d = st[k];
    if (k == 0) d[7] = irq_exp();
    rd_chk(ST_L_ADDR + 8'(k), d);
  endtask
  task automatic st_clr(input int k, input int n);
    wr(ST_L_ADDR + 8'(k), ~(8'h01 << n));
    st[k][n] = 1'b0;
  endtask
  task automatic pulse(input int k);
    evt[k] = 1'b1;
    @(negedge clk_sys);
    evt[k] = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic do_reset(input int n);
    reset = 1'b1;
    repeat (n) @(negedge clk_sys);
    reset = 1'b0;
    st = '{8'h00, 8'h00, 8'h80};
    en = '{8'h00, 8'h00, 8'h00};
    cal_m = 8'h00;
    @(negedge clk_sys);
  endtask
  // ****************************************************************
  // clock, timeout, result monitor
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rd_seen <= sfr_req.rd;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end
  always @(negedge clk_sys) begin
    if (rd_seen === 1'b1 && notes.size() > 0) begin
      check("read", {sfr_rdata, irq_pending, current_use_a, current_use_b,
        voltage_input_ground, current_input_ground}, notes.pop_front());
    end
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    void'($urandom(32'hCD45));
    {sfr_req, evt, fault_dir_sel, reactive_dir_sel, active_dir_sel} = '0;
    {cur_mag, volt_mag, zx_lim, cyc_lim} = '0;
    tamper_pick_b = 1'($urandom);
    cur_thr = MAG_W'($urandom) >> 1;
    volt_thr = MAG_W'($urandom) >> 1;
    do_reset(4);
    for (int i = 0; i < 3; i++) begin
      st_chk(i);
      d_w = 8'($urandom);
      wr(EN_L_ADDR + 8'(i), d_w);
      en[i] = d_w & en_mask[i];
      rd_chk(EN_L_ADDR + 8'(i), en[i]);
    end
    rd_chk(8'h50, 8'h00);
    $display("test reset_and_enables done");
    for (int i = 0; i < 8; i++) begin
      d_w = 8'($urandom) & CAL_WMASK;
      d_w[5:4] = 2'(i);
      tamper_pick_b = 1'($urandom);
      wr(CAL_ADDR, d_w);
      cal_m = d_w;
      rd_chk(CAL_ADDR, d_w);
    end
    $display("test calibration done");
    wr(ST_H_ADDR, 8'h00);
    st[2] = 8'h00;
    for (int i = 0; i < 14; i++) begin
      r = tab_r[i];
      b = tab_b[i];
      d_w = 1'($urandom) ? (8'h01 << b) : 8'h00;
      wr(EN_L_ADDR + 8'(r), d_w);
      en[r] = d_w & en_mask[r];
      pulse(tab_e[i]);
      st[r][b] = 1'b1;
      st_chk(r);
      st_clr(r, b);
      st_chk(r);
    end
    evt.active_noload = 1'b1;
    sfr_req.addr = ST_L_ADDR;
    sfr_req.wdata = 8'hFE;
    sfr_req.wr = 1'b1;
    @(negedge clk_sys);
    evt.active_noload = 1'b0;
    sfr_req.wr = 1'b0;
    @(negedge clk_sys);
    st[0][0] = 1'b1;
    st_chk(0);
    st_clr(0, 0);
    $display("test event_flags done");
    for (int i = 0; i < 6; i++) begin
      b = 5 - i % 3;
      {fault_dir_sel, reactive_dir_sel, active_dir_sel} = (i / 3) ? 3'h7 : 3'h0;
      @(negedge clk_sys);
      for (int k = 0; k < 2; k++) begin
        evt[18 - i % 3] = (k == 0);
        repeat (2) @(negedge clk_sys);
        st[0][b] = (k == i / 3);
        st_chk(0);
        st_clr(0, b);
      end
    end
    $display("test sign_direction done");
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 2; k++) begin
        cur_mag = (i == 0) ? cur_thr + MAG_W'(k) : '0;
        volt_mag = (i == 1) ? volt_thr + MAG_W'(k) : '0;
        @(negedge clk_sys);
        {cur_mag, volt_mag} = '0;
        @(negedge clk_sys);
        st[2][4 - i] = (k == 1);
        st_chk(2);
      end
      st_clr(2, 4 - i);
    end
    $display("test peak_levels done");
    wr(CAL_ADDR, 8'h2C);
    do_reset(2);
    st_chk(2);
    rd_chk(CAL_ADDR, 8'h00);
    $display("test mid_reset done");
    wr(ST_H_ADDR, 8'h00);
    st[2] = 8'h00;
    cyc_lim = 16'h0003;
    zx_lim = 12'h002;
    for (int i = 1; i <= 3; i++) begin
      evt.voltage_sign = ~evt.voltage_sign;
      repeat (2) @(negedge clk_sys);
      st[2][0] = 1'b1;
      st[2][2] = (i == 3);
      st_chk(2);
    end
    wr(ST_H_ADDR, 8'h00);
    st[2] = 8'h00;
    for (int i = 1; i <= 2; i++) begin
      pulse(1);
      st[2][1] = (i == 2);
      st_chk(2);
    end
    $display("test zero_cross done");
    repeat (2) @(negedge clk_sys);
    test_done();
  end
endmodule
`default_nettype wire
